// File: include/cic_pkg.sv
// Constants shared by the core interrupt control block
package cic_pkg;

  // ****************************************
  // Data space layout
  // ****************************************
  localparam int unsigned   CIC_OFFSET_W      = 7;
  localparam int unsigned   CIC_ADDR_W        = 9;
  localparam logic [6:0]    CIC_BANK_TOP      = 7'h7F;
  localparam int unsigned   CIC_BANK_HI_BIT   = 6;
  localparam int unsigned   CIC_BANK_LO_BIT   = 5;
  localparam logic [8:0]    CIC_CORE_ADDR_B0  = 9'h00B;
  localparam logic [8:0]    CIC_CORE_ADDR_B1  = 9'h08B;
  localparam logic [8:0]    CIC_CORE_ADDR_B2  = 9'h10B;
  localparam logic [8:0]    CIC_CORE_ADDR_B3  = 9'h18B;
  localparam logic [8:0]    CIC_PFLAG_ADDR    = 9'h00C;
  localparam logic [8:0]    CIC_PEN_ADDR      = 9'h08C;

  // ****************************************
  // Core control register fields
  // ****************************************
  localparam int unsigned   CIC_GLOBAL_EN_BIT   = 7;
  localparam int unsigned   CIC_GROUP_EN_BIT    = 6;
  localparam int unsigned   CIC_TIMER0_EN_BIT   = 5;
  localparam int unsigned   CIC_EXTIE_BIT       = 4;
  localparam int unsigned   CIC_PCIE_BIT        = 3;
  localparam int unsigned   CIC_TIMER0_FLAG_BIT = 2;
  localparam int unsigned   CIC_EXTIF_BIT     = 1;
  localparam int unsigned   CIC_PCIF_BIT      = 0;

  // ****************************************
  // Peripheral enable and flag fields
  // ****************************************
  localparam int unsigned   CIC_PAR_PORT_BIT  = 7;
  localparam int unsigned   CIC_CONV_BIT      = 6;
  localparam int unsigned   CIC_SER_RX_BIT    = 5;
  localparam int unsigned   CIC_SER_TX_BIT    = 4;
  localparam int unsigned   CIC_SYNC_SER_BIT  = 3;
  localparam int unsigned   CIC_CAPCMP1_BIT   = 2;
  localparam int unsigned   CIC_TMR2_BIT      = 1;
  localparam int unsigned   CIC_TMR1_BIT      = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]    CIC_CORE_RST      = 8'h00;
  localparam logic [7:0]    CIC_PFLAG_RST     = 8'h00;
  localparam logic [7:0]    CIC_PEN_RST       = 8'h00;
  localparam logic [7:0]    CIC_RDATA_RST     = 8'h00;
  localparam logic [3:0]    CIC_PINS_RST      = 4'h0;

endpackage : cic_pkg

// File: include/cic_evt_if.sv
// Pin event signals passed from the pin watcher to the control logic
`timescale 1ns/1ps
`default_nettype none

interface cic_evt_if;
  logic ext_edge;
  logic port_mismatch;

  modport src (output ext_edge, output port_mismatch);
  modport dst (input ext_edge, input port_mismatch);
endinterface : cic_evt_if

`default_nettype wire

// File: design/cic_pin_watch.sv
// Pin synchronisers, external edge detect and upper port mismatch detect
`timescale 1ns/1ps
`default_nettype none

module cic_pin_watch
  import cic_pkg::*;
#(
  parameter int unsigned PORT_W = 4
)
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              external_irq_pin,
  input  wire logic [PORT_W-1:0] upper_port_pins,
  input  wire logic              port_read,
  cic_evt_if.src                 evt
);

  // ****************************************
  // State
  // ****************************************
  logic              ext_s1;
  logic              ext_s2;
  logic              ext_prev;
  logic [PORT_W-1:0] port_s1;
  logic [PORT_W-1:0] port_s2;
  logic [PORT_W-1:0] port_ref;
  logic [PORT_W-1:0] next_port_ref;

  // Reference follows the pins only when software reads the port
  always_comb
  begin
    next_port_ref = port_ref;
    if (port_read)
    begin
      next_port_ref = port_s2;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_s1   <= 1'b0;
      ext_s2   <= 1'b0;
      ext_prev <= 1'b0;
      port_s1  <= PORT_W'(CIC_PINS_RST);
      port_s2  <= PORT_W'(CIC_PINS_RST);
      port_ref <= PORT_W'(CIC_PINS_RST);
    end
    else
    begin
      ext_s1   <= external_irq_pin;
      ext_s2   <= ext_s1;
      ext_prev <= ext_s2;
      port_s1  <= upper_port_pins;
      port_s2  <= port_s1;
      port_ref <= next_port_ref;
    end
  end

  // ****************************************
  // Events
  // ****************************************
  assign evt.ext_edge      = ext_s2 & ~ext_prev;
  assign evt.port_mismatch = (port_s2 != port_ref);

endmodule : cic_pin_watch

`default_nettype wire

// File: design/cic_core_irq.sv
// Core interrupt control registers and request to the processor core
`timescale 1ns/1ps
`default_nettype none

module cic_core_irq
  import cic_pkg::*;
#(
  parameter int unsigned PORT_W       = 4,
  parameter bit          HAS_PAR_PORT = 1'b1
)
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    warm_rst,
  input  wire logic [7:0]              status_reg,
  input  wire logic [CIC_OFFSET_W-1:0] addr_offset,
  input  wire logic                    rd_en,
  input  wire logic                    wr_en,
  input  wire logic [7:0]              wdata,
  input  wire logic                    timer0_overflow,
  input  wire logic [7:0]              periph_events,
  input  wire logic                    external_irq_pin,
  input  wire logic [PORT_W-1:0]       upper_port_pins,
  input  wire logic                    port_read,
  output var  logic [7:0]              rdata,
  output var  logic                    irq_request
);

  // ****************************************
  // Pin watcher
  // ****************************************
  cic_evt_if evt ();

  cic_pin_watch #(
    .PORT_W (PORT_W)
  ) u_pin_watch (
    .clk              (clk),
    .nrst             (nrst),
    .external_irq_pin (external_irq_pin),
    .upper_port_pins  (upper_port_pins),
    .port_read        (port_read),
    .evt              (evt.src)
  );

  // ****************************************
  // Registers and next values
  // ****************************************
  logic [7:0]            core_irq_control;
  logic [7:0]            peripheral_irq_flags;
  logic [7:0]            peripheral_irq_enables;
  logic [7:0]            next_core_irq_control;
  logic [7:0]            next_peripheral_irq_flags;
  logic [7:0]            next_peripheral_irq_enables;
  logic [7:0]            next_rdata;
  logic                  next_irq_request;
  logic [CIC_ADDR_W-1:0] full_addr;
  logic                  hit_core;
  logic                  hit_pflag;
  logic                  hit_pen;
  logic [7:0]            pen_mask;
  logic                  core_pending;
  logic                  periph_pending;

  // ****************************************
  // Address decode
  // ****************************************
  always_comb
  begin
    full_addr = {status_reg[CIC_BANK_HI_BIT], status_reg[CIC_BANK_LO_BIT],
                 addr_offset};
    hit_core  = (full_addr == CIC_CORE_ADDR_B0) ||
                (full_addr == CIC_CORE_ADDR_B1) ||
                (full_addr == CIC_CORE_ADDR_B2) ||
                (full_addr == CIC_CORE_ADDR_B3);
    hit_pflag = (full_addr == CIC_PFLAG_ADDR);
    hit_pen   = (full_addr == CIC_PEN_ADDR);
    pen_mask  = 8'hFF;
    if (!HAS_PAR_PORT)
    begin
      pen_mask[CIC_PAR_PORT_BIT] = 1'b0;
    end
  end

  // ****************************************
  // Core control register
  // ****************************************
  always_comb
  begin
    next_core_irq_control = core_irq_control;
    if (warm_rst)
    begin
      next_core_irq_control = CIC_CORE_RST;
      next_core_irq_control[CIC_PCIF_BIT] =
        core_irq_control[CIC_PCIF_BIT];
    end
    else
    begin
      if (wr_en && hit_core)
      begin
        next_core_irq_control = wdata;
      end
      if (timer0_overflow)
      begin
        next_core_irq_control[CIC_TIMER0_FLAG_BIT] = 1'b1;
      end
      if (evt.ext_edge)
      begin
        next_core_irq_control[CIC_EXTIF_BIT] = 1'b1;
      end
      if (evt.port_mismatch)
      begin
        next_core_irq_control[CIC_PCIF_BIT] = 1'b1;
      end
    end
  end

  // ****************************************
  // Peripheral flag and enable registers
  // ****************************************
  always_comb
  begin
    next_peripheral_irq_flags   = peripheral_irq_flags;
    next_peripheral_irq_enables = peripheral_irq_enables;
    if (warm_rst)
    begin
      next_peripheral_irq_flags   = CIC_PFLAG_RST;
      next_peripheral_irq_enables = CIC_PEN_RST;
    end
    else
    begin
      if (wr_en && hit_pflag)
      begin
        next_peripheral_irq_flags = wdata;
      end
      if (wr_en && hit_pen)
      begin
        next_peripheral_irq_enables = wdata & pen_mask;
      end
      next_peripheral_irq_flags =
        next_peripheral_irq_flags | periph_events;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb
  begin
    next_rdata = CIC_RDATA_RST;
    if (rd_en)
    begin
      if (hit_core)
      begin
        next_rdata = core_irq_control;
      end
      else if (hit_pflag)
      begin
        next_rdata = peripheral_irq_flags;
      end
      else if (hit_pen)
      begin
        next_rdata = peripheral_irq_enables;
      end
      else
      begin
        next_rdata = CIC_RDATA_RST;
      end
    end
  end

  // ****************************************
  // Request to the core
  // ****************************************
  always_comb
  begin
    core_pending     =
      (core_irq_control[CIC_TIMER0_EN_BIT] & core_irq_control[CIC_TIMER0_FLAG_BIT]) |
      (core_irq_control[CIC_EXTIE_BIT]     & core_irq_control[CIC_EXTIF_BIT])       |
      (core_irq_control[CIC_PCIE_BIT]      & core_irq_control[CIC_PCIF_BIT]);
    // Peripheral flags count only under the group enable
    periph_pending   = core_irq_control[CIC_GROUP_EN_BIT] &
      (|(peripheral_irq_enables & peripheral_irq_flags));
    next_irq_request = core_irq_control[CIC_GLOBAL_EN_BIT] &
      (core_pending | periph_pending);
  end

  // ****************************************
  // Register stage
  // ****************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_irq_control       <= CIC_CORE_RST;
      peripheral_irq_flags   <= CIC_PFLAG_RST;
      peripheral_irq_enables <= CIC_PEN_RST;
      rdata                  <= CIC_RDATA_RST;
      irq_request            <= 1'b0;
    end
    else
    begin
      core_irq_control       <= next_core_irq_control;
      peripheral_irq_flags   <= next_peripheral_irq_flags;
      peripheral_irq_enables <= next_peripheral_irq_enables;
      rdata                  <= next_rdata;
      irq_request            <= next_irq_request;
    end
  end

endmodule : cic_core_irq

`default_nettype wire

// File: sim/cic_chk_props.sv
// Port checks for the core interrupt control block
`timescale 1ns/1ps
`default_nettype none

module cic_chk
  import cic_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    warm_rst,
  input wire logic [7:0]              status_reg,
  input wire logic [CIC_OFFSET_W-1:0] addr_offset,
  input wire logic                    rd_en,
  input wire logic                    wr_en,
  input wire logic [7:0]              wdata,
  input wire logic                    timer0_overflow,
  input wire logic [7:0]              periph_events,
  input wire logic [7:0]              rdata,
  input wire logic                    irq_request
);
  wire logic cor = addr_offset == 7'h0B;
  wire logic pfl = addr_offset == 7'h0C && status_reg[6:5] == 2'b00;
  wire logic pen = addr_offset == 7'h0C && status_reg[6:5] == 2'b01;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_rd(a); rd_en && !warm_rst && a; endsequence
  sequence s_wr(a); wr_en && !warm_rst && a; endsequence
  sequence s_gap; !(wr_en || warm_rst); endsequence

  a_idle_zero: assert property (!rd_en |=> rdata == 8'h00)
    else $error("rdata not zero without a read");
  a_unmapped_zero: assert property (rd_en && !(cor || pfl || pen) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_core_mirror: assert property (s_wr(cor) ##1 s_gap ##1 s_rd(cor)
    |=> ((rdata ^ $past(wdata, 3)) & 8'hF8) == 8'h00)
    else $error("core enables lost across banks");
  a_pen_store: assert property (s_wr(pen) ##1 s_gap ##1 s_rd(pen)
    |=> ((rdata ^ $past(wdata, 3)) & 8'h7F) == 8'h00)
    else $error("peripheral enables not stored");
  a_global_blocks: assert property (s_rd(cor) ##1 !rdata[7] |-> !irq_request)
    else $error("request with global enable clear");
  a_core_request: assert property (s_rd(cor) ##1 (rdata[7] && |(rdata[5:3] & rdata[2:0]))
    |-> irq_request)
    else $error("missing core request");
  a_t0_set_wins: assert property (timer0_overflow && !warm_rst ##1 s_gap ##1 s_rd(cor)
    |=> rdata[2])
    else $error("timer0 flag not set");
  a_pflag_set: assert property (periph_events != 8'h00 && !warm_rst ##1 s_gap ##1 s_rd(pfl)
    |=> (rdata & $past(periph_events, 3)) == $past(periph_events, 3))
    else $error("peripheral flag not set");
  a_warm_quiet: assert property (warm_rst |=> ##1 !irq_request)
    else $error("request after warm reset");
endmodule : cic_chk

bind cic_core_irq cic_chk i_cic_chk (.clk(clk), .nrst(nrst), .warm_rst(warm_rst),
  .status_reg(status_reg), .addr_offset(addr_offset), .rd_en(rd_en), .wr_en(wr_en),
  .wdata(wdata), .timer0_overflow(timer0_overflow), .periph_events(periph_events),
  .rdata(rdata), .irq_request(irq_request));

`default_nettype wire

// File: sim/cic_src.sv
// Event sources facing the interrupt control block
`timescale 1ns/1ps
`default_nettype none

module cic_src
  import cic_pkg::*;
#(
  parameter int unsigned PORT_W = 4
)
(
  input  wire logic              clk,
  output var  logic              timer0_overflow,
  output var  logic [7:0]        periph_events,
  output var  logic              external_irq_pin,
  output var  logic [PORT_W-1:0] upper_port_pins
);
  initial
  begin
    timer0_overflow = 1'b0;
    periph_events = 8'h00;
    external_irq_pin = 1'b0;
    upper_port_pins = '0;
  end

  task automatic pulse(input logic t, input logic [7:0] p);
    @(negedge clk);
    timer0_overflow = t;
    periph_events = p;
    @(negedge clk);
    timer0_overflow = 1'b0;
    periph_events = 8'h00;
  endtask : pulse

  task automatic pins(input logic e, input logic [PORT_W-1:0] u);
    @(negedge clk);
    external_irq_pin = e;
    upper_port_pins = u;
  endtask : pins
endmodule : cic_src

`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the core interrupt control block
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cic_pkg::*;
;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       warm_rst = 1'b0;
  logic [7:0] status_reg = 8'h00;
  logic [6:0] addr_offset = 7'h00;
  logic       rd_en = 1'b0;
  logic       wr_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic       port_read = 1'b0;
  wire logic  t0;
  wire logic  ext;
  wire logic  irq;
  wire logic [7:0] pev;
  wire logic [7:0] rdata;
  wire logic [3:0] pins;
  int         n_errors = 0;
  int         total_checks = 0;

  always #5 clk = ~clk;

  cic_src i_cic_src (.clk(clk), .timer0_overflow(t0), .periph_events(pev),
    .external_irq_pin(ext), .upper_port_pins(pins));
  cic_core_irq i_cic_core_irq (.clk(clk), .nrst(nrst), .warm_rst(warm_rst),
    .status_reg(status_reg), .addr_offset(addr_offset), .rd_en(rd_en), .wr_en(wr_en),
    .wdata(wdata), .timer0_overflow(t0), .periph_events(pev), .external_irq_pin(ext),
    .upper_port_pins(pins), .port_read(port_read), .rdata(rdata), .irq_request(irq));

  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [1:0] b, input logic [6:0] o,
                     input logic [7:0] d);
    @(negedge clk);
    status_reg = {1'b0, b, 5'h00};
    addr_offset = o;
    wdata = d;
    wr_en = w;
    rd_en = !w;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b0;
  endtask : acc

  task automatic wr(input logic [1:0] b, input logic [6:0] o, input logic [7:0] d);
    acc(1'b1, b, o, d);
  endtask : wr

  task automatic rd(input logic [1:0] b, input logic [6:0] o, input logic [7:0] e);
    acc(1'b0, b, o, 8'h00);
    chk(rdata, e, "rdata");
  endtask : rd

  task automatic ck_irq(input logic e);
    @(negedge clk);
    chk({7'h00, irq}, {7'h00, e}, "irq_request");
  endtask : ck_irq

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    for (int b = 0; b < 4; b++) rd(b[1:0], 7'h0B, 8'h00);
    rd(2'd0, 7'h0C, 8'h00);
    rd(2'd1, 7'h0C, 8'h00);
    wr(2'd2, 7'h0B, 8'hF8);
    for (int b = 0; b < 4; b++) rd(b[1:0], 7'h0B, 8'hF8);
    rd(2'd3, 7'h0C, 8'h00);
    i_cic_src.pulse(1'b1, 8'h00);
    ck_irq(1'b1);
    rd(2'd0, 7'h0B, 8'hFC);
    wr(2'd0, 7'h0B, 8'h7C);
    ck_irq(1'b0);
    fork
      wr(2'd1, 7'h0B, 8'hF8);
      i_cic_src.pulse(1'b1, 8'h00);
    join
    rd(2'd0, 7'h0B, 8'hFC);
    wr(2'd0, 7'h0B, 8'h80);
    wr(2'd1, 7'h0C, 8'hFF);
    rd(2'd1, 7'h0C, 8'hFF);
    i_cic_src.pulse(1'b0, 8'h81);
    rd(2'd0, 7'h0C, 8'h81);
    ck_irq(1'b0);
    wr(2'd0, 7'h0B, 8'hC0);
    for (int i = 0; i < 8; i++)
    begin
      wr(2'd0, 7'h0C, 8'h00);
      wr(2'd1, 7'h0C, 8'h01 << i);
      i_cic_src.pulse(1'b0, ~(8'h01 << i));
      ck_irq(1'b0);
      i_cic_src.pulse(1'b0, 8'h01 << i);
      ck_irq(1'b1);
    end
    wr(2'd0, 7'h0B, 8'h90);
    i_cic_src.pins(1'b1, 4'h0);
    repeat (4) @(negedge clk);
    ck_irq(1'b1);
    rd(2'd0, 7'h0B, 8'h92);
    wr(2'd0, 7'h0B, 8'h88);
    i_cic_src.pins(1'b0, 4'hA);
    repeat (4) @(negedge clk);
    wr(2'd0, 7'h0B, 8'h88);
    rd(2'd0, 7'h0B, 8'h89);
    @(negedge clk);
    port_read = 1'b1;
    @(negedge clk);
    port_read = 1'b0;
    repeat (3) @(negedge clk);
    wr(2'd0, 7'h0B, 8'h88);
    rd(2'd0, 7'h0B, 8'h88);
    i_cic_src.pins(1'b0, 4'h5);
    repeat (4) @(negedge clk);
    port_read = 1'b1;
    @(negedge clk);
    port_read = 1'b0;
    repeat (3) @(negedge clk);
    warm_rst = 1'b1;
    @(negedge clk);
    warm_rst = 1'b0;
    rd(2'd0, 7'h0B, 8'h01);
    ck_irq(1'b0);
    rd(2'd1, 7'h0C, 8'h00);
    rd(2'd0, 7'h0C, 8'h00);
    wr(2'd1, 7'h0C, 8'h7F);
    rd(2'd1, 7'h0C, 8'h7F);
    i_cic_src.pins(1'b0, 4'h0);
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    rd(2'd0, 7'h0B, 8'h00);
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
